// file: flash_guard_pkg.sv
// Constants shared by the flash write and erase guard
package flash_guard_pkg;
   localparam logic [7:0] CTRL_ADDR = 8'h8f;
   localparam logic [7:0] CTRL_PAGE = 8'h00;
   localparam int WE_BIT = 0;
   localparam int EE_BIT = 1;
   localparam logic [1:0] CTRL_RESET = 2'h0;
   localparam logic [5:0] CTRL_UNUSED_READ = 6'h00;
   localparam int PAGE_MSB = 15;
   localparam int PAGE_LSB = 9;
   localparam int PAGE_W = PAGE_MSB - PAGE_LSB + 1;
   localparam logic [15:0] LOCK_ADDR_LARGE = 16'hfbff;
   localparam logic [15:0] LOCK_ADDR_SMALL = 16'h7fff;
   localparam logic [7:0] LOCK_OPEN = 8'hff;
   localparam logic [7:0] BLOCKED_DATA = 8'h00;
endpackage : flash_guard_pkg

// file: page_lock_check.sv
// Decides whether one flash address falls in a locked page
`timescale 1ns/1ps
module page_lock_check (
   input wire logic [15:0] addr,
   input wire logic [7:0] lock_byte,
   input wire logic mem_large,
   output logic locked
);
   logic [7:0] locked_count;
   logic [7:0] page;
   logic [7:0] lock_page;

   always_comb begin
      locked_count = ~lock_byte;
      page = {1'b0, addr[flash_guard_pkg::PAGE_MSB:flash_guard_pkg::PAGE_LSB]};
      if (mem_large) begin
         lock_page = {1'b0, flash_guard_pkg::LOCK_ADDR_LARGE[flash_guard_pkg::PAGE_MSB:flash_guard_pkg::PAGE_LSB]};
      end else begin
         lock_page = {1'b0, flash_guard_pkg::LOCK_ADDR_SMALL[flash_guard_pkg::PAGE_MSB:flash_guard_pkg::PAGE_LSB]};
      end
      // Pages count up from page zero
      locked = (page < locked_count)
         || ((page == lock_page) && (lock_byte != flash_guard_pkg::LOCK_OPEN));
   end
endmodule : page_lock_check

// file: flash_write_erase_guard.sv
// Program-store control register and flash access guard
//
// Overview of operation
// - Flash read only by code reads and debug reads
// - No core flash change without write enable; debug writes need none
// - Core erase needs write and erase enable; debug erase needs neither
// - Both enables: move write erases page
// - Write enable only: move write programs byte
// - Upper six control bits read zero
// - Lock byte guards pages from unprotected access
// - Locked pages: complement of lock byte
// - Lock byte page locked when any bit zero
// - Control bits reset to zero
// - Lock byte address depends on memory size
// - Flash write or erase without high supply monitor resets
`timescale 1ns/1ps
module flash_write_erase_guard (
   input wire logic core_clk,
   input wire logic sys_rst,
   input wire logic mem_large,
   input wire logic [7:0] sfr_page,
   input wire logic [7:0] sfr_addr,
   input wire logic sfr_wr,
   input wire logic [7:0] sfr_wdata,
   input wire logic sfr_rd,
   output logic [7:0] sfr_rdata,
   input wire logic [15:0] exec_pc,
   input wire logic data_space_move_wr,
   input wire logic data_space_move_rd,
   input wire logic [15:0] data_space_move_addr,
   input wire logic [7:0] data_space_move_wdata,
   input wire logic code_rd,
   input wire logic [15:0] code_addr,
   output logic [7:0] code_rdata,
   output logic code_rvalid,
   input wire logic dbg_rd,
   input wire logic dbg_wr,
   input wire logic dbg_erase,
   input wire logic [15:0] dbg_addr,
   input wire logic [7:0] dbg_wdata,
   output logic [7:0] dbg_rdata,
   output logic dbg_rvalid,
   output logic dbg_refused,
   input wire logic [7:0] lock_byte,
   input wire logic supply_monitor_enable,
   input wire logic supply_monitor_high_level,
   output logic external_data_ram_wr,
   output logic external_data_ram_rd,
   output logic [15:0] external_data_ram_addr,
   output logic [7:0] external_data_ram_wdata,
   output logic flash_prog,
   output logic flash_erase,
   output logic [15:0] flash_addr,
   output logic [7:0] flash_wdata,
   output logic flash_rd,
   output logic [15:0] flash_raddr,
   input wire logic [7:0] flash_rdata,
   output logic flash_error_reset,
   output logic flash_blocked
);

   ////////////////////////////////////////////////////////////////////////////
   // Control register

   logic flash_write_enable_reg;
   logic flash_erase_enable_reg;
   logic ctrl_hit;

   assign ctrl_hit = (sfr_addr == flash_guard_pkg::CTRL_ADDR) && (sfr_page == flash_guard_pkg::CTRL_PAGE);

   always_ff @(posedge core_clk) begin
      if (sys_rst) begin
         flash_write_enable_reg <= flash_guard_pkg::CTRL_RESET[flash_guard_pkg::WE_BIT];
         flash_erase_enable_reg <= flash_guard_pkg::CTRL_RESET[flash_guard_pkg::EE_BIT];
      end else if (sfr_wr && ctrl_hit) begin
         // Upper bits are dropped
         flash_write_enable_reg <= sfr_wdata[flash_guard_pkg::WE_BIT];
         flash_erase_enable_reg <= sfr_wdata[flash_guard_pkg::EE_BIT];
      end
   end

   always_ff @(posedge core_clk) begin
      if (sys_rst) begin
         sfr_rdata <= 8'h00;
      end else if (sfr_rd && ctrl_hit) begin
         sfr_rdata <= {flash_guard_pkg::CTRL_UNUSED_READ, flash_erase_enable_reg, flash_write_enable_reg};
      end else begin
         sfr_rdata <= 8'h00;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Page lock decode

   logic pc_locked;
   logic data_space_move_locked;
   logic code_locked;
   logic dbg_locked;

   page_lock_check pc_check (
      .addr(exec_pc),
      .lock_byte(lock_byte),
      .mem_large(mem_large),
      .locked(pc_locked)
   );

   page_lock_check data_space_move_check (
      .addr(data_space_move_addr),
      .lock_byte(lock_byte),
      .mem_large(mem_large),
      .locked(data_space_move_locked)
   );

   page_lock_check code_check (
      .addr(code_addr),
      .lock_byte(lock_byte),
      .mem_large(mem_large),
      .locked(code_locked)
   );

   page_lock_check dbg_check (
      .addr(dbg_addr),
      .lock_byte(lock_byte),
      .mem_large(mem_large),
      .locked(dbg_locked)
   );

   ////////////////////////////////////////////////////////////////////////////
   // Write and erase steering

   logic core_flash_op;
   logic core_deny;
   logic dbg_op;
   logic supply_ok;

   // Code running from a locked page counts as protected
   assign core_flash_op = data_space_move_wr && flash_write_enable_reg;
   assign core_deny = data_space_move_locked && !pc_locked;
   assign dbg_op = dbg_wr || dbg_erase;
   assign supply_ok = supply_monitor_enable && supply_monitor_high_level;

   always_ff @(posedge core_clk) begin
      if (sys_rst) begin
         flash_prog <= 1'b0;
         flash_erase <= 1'b0;
         flash_addr <= 16'h0000;
         flash_wdata <= 8'h00;
         flash_error_reset <= 1'b0;
         flash_blocked <= 1'b0;
         dbg_refused <= 1'b0;
      end else begin
         flash_prog <= 1'b0;
         flash_erase <= 1'b0;
         flash_error_reset <= 1'b0;
         flash_blocked <= 1'b0;
         dbg_refused <= 1'b0;
         if (core_flash_op) begin
            dbg_refused <= dbg_op;
            flash_addr <= data_space_move_addr;
            flash_wdata <= data_space_move_wdata;
            if (!supply_ok) begin
               flash_error_reset <= 1'b1;
            end else if (core_deny) begin
               flash_blocked <= 1'b1;
            end else if (flash_erase_enable_reg) begin
               flash_erase <= 1'b1;
            end else begin
               flash_prog <= 1'b1;
            end
         end else if (dbg_op) begin
            flash_addr <= dbg_addr;
            flash_wdata <= dbg_wdata;
            if (!supply_ok) begin
               flash_error_reset <= 1'b1;
            end else if (dbg_locked) begin
               flash_blocked <= 1'b1;
            end else begin
               flash_erase <= dbg_erase;
               flash_prog <= !dbg_erase;
            end
         end
      end
   end

   // Move reads always go to data RAM, whatever the enables hold
   always_ff @(posedge core_clk) begin
      if (sys_rst) begin
         external_data_ram_wr <= 1'b0;
         external_data_ram_rd <= 1'b0;
         external_data_ram_addr <= 16'h0000;
         external_data_ram_wdata <= 8'h00;
      end else begin
         external_data_ram_wr <= data_space_move_wr && !flash_write_enable_reg;
         external_data_ram_rd <= data_space_move_rd;
         if (data_space_move_wr || data_space_move_rd) begin
            external_data_ram_addr <= data_space_move_addr;
            external_data_ram_wdata <= data_space_move_wdata;
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Read path: code reads first, debug reads second

   logic rd1_valid_reg;
   logic rd1_dbg_reg;
   logic rd1_ok_reg;
   logic rd2_valid_reg;
   logic rd2_dbg_reg;
   logic rd2_ok_reg;
   logic dbg_rd_taken;

   assign dbg_rd_taken = dbg_rd && !code_rd;

   always_ff @(posedge core_clk) begin
      if (sys_rst) begin
         rd1_valid_reg <= 1'b0;
         rd1_dbg_reg <= 1'b0;
         rd1_ok_reg <= 1'b0;
         flash_rd <= 1'b0;
         flash_raddr <= 16'h0000;
      end else begin
         rd1_valid_reg <= code_rd || dbg_rd_taken;
         rd1_dbg_reg <= dbg_rd_taken;
         if (code_rd) begin
            rd1_ok_reg <= !(code_locked && !pc_locked);
            flash_rd <= !(code_locked && !pc_locked);
            flash_raddr <= code_addr;
         end else if (dbg_rd_taken) begin
            rd1_ok_reg <= !dbg_locked;
            flash_rd <= !dbg_locked;
            flash_raddr <= dbg_addr;
         end else begin
            rd1_ok_reg <= 1'b0;
            flash_rd <= 1'b0;
         end
      end
   end

   always_ff @(posedge core_clk) begin
      if (sys_rst) begin
         rd2_valid_reg <= 1'b0;
         rd2_dbg_reg <= 1'b0;
         rd2_ok_reg <= 1'b0;
      end else begin
         rd2_valid_reg <= rd1_valid_reg;
         rd2_dbg_reg <= rd1_dbg_reg;
         rd2_ok_reg <= rd1_ok_reg;
      end
   end

   always_ff @(posedge core_clk) begin
      if (sys_rst) begin
         code_rdata <= 8'h00;
         code_rvalid <= 1'b0;
         dbg_rdata <= 8'h00;
         dbg_rvalid <= 1'b0;
      end else begin
         code_rvalid <= rd2_valid_reg && !rd2_dbg_reg;
         dbg_rvalid <= rd2_valid_reg && rd2_dbg_reg;
         if (rd2_valid_reg && !rd2_dbg_reg) begin
            code_rdata <= rd2_ok_reg ? flash_rdata : flash_guard_pkg::BLOCKED_DATA;
         end
         if (rd2_valid_reg && rd2_dbg_reg) begin
            dbg_rdata <= rd2_ok_reg ? flash_rdata : flash_guard_pkg::BLOCKED_DATA;
         end
      end
   end

endmodule : flash_write_erase_guard

// file: fweg_props.sv
// Assertion checker for the flash write and erase guard
`timescale 1ns/1ps
module fweg_props (
   input wire logic core_clk,
   input wire logic sys_rst,
   input wire logic sfr_wr,
   input wire logic data_space_move_wr,
   input wire logic data_space_move_rd,
   input wire logic code_rd,
   input wire logic code_rvalid,
   input wire logic dbg_rd,
   input wire logic dbg_wr,
   input wire logic dbg_rvalid,
   input wire logic external_data_ram_wr,
   input wire logic external_data_ram_rd,
   input wire logic flash_prog,
   input wire logic flash_erase,
   input wire logic flash_rd,
   input wire logic flash_error_reset,
   input wire logic flash_blocked,
   input wire logic supply_monitor_enable,
   input wire logic supply_monitor_high_level,
   input wire logic [7:0] sfr_page,
   input wire logic [7:0] sfr_addr,
   input wire logic [7:0] sfr_wdata,
   input wire logic [7:0] sfr_rdata,
   input wire logic [7:0] data_space_move_wdata,
   input wire logic [7:0] dbg_rdata,
   input wire logic [7:0] lock_byte,
   input wire logic [7:0] flash_wdata,
   input wire logic [15:0] data_space_move_addr,
   input wire logic [15:0] dbg_addr,
   input wire logic [15:0] flash_addr
);
   logic [1:0] en_reg;
   logic ok;
   assign ok = supply_monitor_enable & supply_monitor_high_level;
   // Shadow of the two enable bits
   always_ff @(posedge core_clk) begin
      if (sys_rst) en_reg <= 2'h0;
      else if (sfr_wr && sfr_addr == 8'h8f && sfr_page == 8'h00) en_reg <= sfr_wdata[1:0];
   end
   default clocking @(posedge core_clk); endclocking
   default disable iff (sys_rst);
   a_move_read_ram: assert property (data_space_move_rd && !code_rd && !dbg_rd |=> external_data_ram_rd && !flash_rd)
      else $error("move read reached flash");
   a_code_read_lat: assert property (code_rd |-> ##3 code_rvalid)
      else $error("code read answer late");
   a_write_off_ram: assert property (data_space_move_wr && !en_reg[0] && !dbg_wr |=> external_data_ram_wr && !flash_prog && !flash_erase)
      else $error("flash changed while disabled");
   a_erase_page: assert property (data_space_move_wr && en_reg == 2'h3 && ok && lock_byte == 8'hff
      |=> flash_erase && !flash_prog && !external_data_ram_wr)
      else $error("erase not issued");
   a_prog_byte: assert property (data_space_move_wr && en_reg == 2'h1 && ok && lock_byte == 8'hff
      |=> flash_prog && flash_addr == $past(data_space_move_addr) && flash_wdata == $past(data_space_move_wdata))
      else $error("byte program wrong");
   a_upper_zero: assert property (sfr_rdata[7:2] == 6'h00)
      else $error("upper control bits not zero");
   a_supply_error: assert property (data_space_move_wr && en_reg[0] && !ok |=> flash_error_reset && !flash_prog && !flash_erase)
      else $error("no flash error reset");
   a_debug_locked: assert property (dbg_wr && !data_space_move_wr && ok && dbg_addr[15:9] == 7'h00 && lock_byte != 8'hff
      |=> flash_blocked && !flash_prog)
      else $error("locked page written");
   a_blocked_read: assert property (dbg_rd && !code_rd && dbg_addr[15:9] == 7'h00 && lock_byte != 8'hff
      |=> !flash_rd ##2 dbg_rvalid && dbg_rdata == 8'h00)
      else $error("locked page read");
endmodule : fweg_props
////////////////////////////////////////
bind flash_write_erase_guard fweg_props chk (.*);

// file: flash_array_model.sv
// Behavioural program flash array behind the guard
`timescale 1ns/1ps
module flash_array_model (
   input wire logic core_clk, flash_prog, flash_erase, flash_rd,
   input wire logic [15:0] flash_addr, flash_raddr,
   input wire logic [7:0] flash_wdata,
   output logic [7:0] flash_rdata
);
   logic [7:0] mem [65536];
   initial begin
      foreach (mem[i]) mem[i] = 8'hff;
      flash_rdata = 8'h00;
   end
   // Programming only clears bits, so unerased bytes keep old zeros
   always @(posedge core_clk) begin
      if (flash_prog) mem[flash_addr] = mem[flash_addr] & flash_wdata;
      if (flash_erase) for (int i = 0; i < 512; i++) mem[{flash_addr[15:9], 9'h000} + i] = 8'hff;
      flash_rdata <= flash_rd ? mem[flash_raddr] : ~flash_rdata;
   end
endmodule : flash_array_model

// file: tb_top.sv
// Self-checking testbench for the flash write and erase guard
`timescale 1ns/1ps
module tb_top;
   logic core_clk, sys_rst, mem_large, sfr_wr, sfr_rd, data_space_move_wr, data_space_move_rd, code_rd, dbg_rd, dbg_wr, dbg_erase;
   logic supply_monitor_enable, supply_monitor_high_level, code_rvalid, dbg_rvalid, dbg_refused;
   logic external_data_ram_wr, external_data_ram_rd, flash_prog, flash_erase, flash_rd, flash_error_reset, flash_blocked;
   logic [7:0] sfr_page, sfr_addr, sfr_wdata, sfr_rdata, data_space_move_wdata, code_rdata, dbg_wdata, dbg_rdata;
   logic [7:0] lock_byte, external_data_ram_wdata, flash_wdata, flash_rdata;
   logic [15:0] exec_pc, data_space_move_addr, code_addr, dbg_addr, external_data_ram_addr, flash_addr, flash_raddr;
   int err_total = 0;
   int n_checks = 0;
   flash_write_erase_guard dut (.*);
   flash_array_model flash (.*);
   initial begin
      core_clk = 0;
      forever #2.5 core_clk = ~core_clk;
   end
   ////////////////////////////////////////
   task automatic chk(input logic [23:0] got, input logic [23:0] exp);
      n_checks++;
      if (got !== exp) begin
         err_total++;
         $display("[ERR] %0t got %h want %h", $time, got, exp);
      end
   endtask : chk
   task automatic sfr(input logic w, input logic [7:0] d);
      @(negedge core_clk);
      {sfr_wr, sfr_rd} = {w, !w};
      sfr_wdata = d;
      @(negedge core_clk);
      {sfr_wr, sfr_rd} = 2'h0;
   endtask : sfr
   // Kind 0 move write, 1 move read, 2 debug write
   task automatic op(input int k, input logic [15:0] a, input logic [7:0] d);
      @(negedge core_clk);
      {dbg_wr, data_space_move_rd, data_space_move_wr} = 3'h1 << k;
      {data_space_move_addr, dbg_addr, data_space_move_wdata, dbg_wdata} = {a, a, d, d};
      @(negedge core_clk);
      {dbg_wr, data_space_move_rd, data_space_move_wr} = 3'h0;
   endtask : op
   task automatic ob(input logic [4:0] e);
      chk({external_data_ram_wr, flash_prog, flash_erase, flash_blocked, flash_error_reset}, e);
   endtask : ob
   // Kind 0 code read, 1 debug read
   task automatic rd(input int k, input logic [15:0] a, input logic [7:0] e);
      @(negedge core_clk);
      {dbg_rd, code_rd} = 2'h1 << k;
      {code_addr, dbg_addr} = {a, a};
      @(negedge core_clk);
      {dbg_rd, code_rd} = 2'h0;
      repeat (2) @(negedge core_clk);
      chk(k ? {dbg_rvalid, dbg_rdata} : {code_rvalid, code_rdata}, {1'b1, e});
   endtask : rd
   task automatic lk(input logic [7:0] lb, input logic [15:0] pc, input int k, input logic [15:0] a, input logic b);
      lock_byte = lb;
      exec_pc = pc;
      op(k, a, 8'h00);
      chk({flash_blocked, flash_prog}, {b, !b});
   endtask : lk
   task automatic conclude();
      $display("checks %0d errors %0d", n_checks, err_total);
      if (err_total == 0 && n_checks > 0) $display("Testbench passed");
      else $display("Testbench failed");
      $finish;
   endtask : conclude
   initial begin
      #20000;
      err_total++;
      conclude();
   end
   initial begin
      {sys_rst, mem_large, supply_monitor_enable, supply_monitor_high_level} = 4'hf;
      {sfr_wr, sfr_rd, data_space_move_wr, data_space_move_rd, code_rd, dbg_rd, dbg_wr, dbg_erase} = 8'h00;
      {sfr_page, sfr_addr, sfr_wdata, data_space_move_wdata, dbg_wdata, lock_byte} = 48'h008f000000ff;
      {exec_pc, data_space_move_addr, code_addr, dbg_addr} = 64'h8000000000000000;
      repeat (10) @(negedge core_clk);
      sys_rst = 0;
      sfr(0, 8'h00); chk(sfr_rdata, 8'h00);
      sfr(1, 8'hff); sfr(0, 8'h00); chk(sfr_rdata, 8'h03);
      sfr(1, 8'h02); op(0, 16'h1234, 8'h5a); ob(5'b10000);
      chk({external_data_ram_addr, external_data_ram_wdata}, 24'h12345a);
      sfr(1, 8'h01); op(0, 16'h0400, 8'h3c); ob(5'b01000);
      chk({flash_addr, flash_wdata}, 24'h04003c);
      op(1, 16'h0400, 8'h00); chk({external_data_ram_rd, flash_rd}, 2'b10);
      rd(0, 16'h0400, 8'h3c);
      sfr(1, 8'h03); op(0, 16'h0401, 8'h77); ob(5'b00100);
      rd(0, 16'h0400, 8'hff);
      supply_monitor_high_level = 0;
      op(0, 16'h0400, 8'h00); ob(5'b00001);
      supply_monitor_high_level = 1;
      sfr(1, 8'h01);
      lk(8'hfd, 16'h8000, 0, 16'h0200, 1);
      lk(8'hfd, 16'h8000, 0, 16'h0400, 0);
      lk(8'hfd, 16'h0000, 0, 16'h0200, 0);
      lk(8'hfd, 16'h0000, 2, 16'h0000, 1);
      lk(8'hfd, 16'h8000, 2, 16'hfb00, 1);
      lk(8'hff, 16'h8000, 2, 16'hfb00, 0);
      mem_large = 0;
      lk(8'hfe, 16'h8000, 2, 16'h7e00, 1);
      rd(1, 16'h0000, 8'h00);
      // Core flash write and debug write together: core wins
      lock_byte = 8'hff;
      {data_space_move_addr, dbg_addr, data_space_move_wdata, dbg_wdata} = {16'h0400, 16'h0600, 8'h11, 8'h22};
      {data_space_move_wr, dbg_wr} = 2'b11;
      @(negedge core_clk);
      {data_space_move_wr, dbg_wr} = 2'b00;
      chk({dbg_refused, flash_prog, flash_addr}, {2'b11, 16'h0400});
      // Debug erase of an unlocked page
      dbg_erase = 1;
      @(negedge core_clk);
      dbg_erase = 0;
      chk({flash_erase, flash_prog, flash_blocked, flash_addr}, {3'b100, 16'h0600});
      conclude();
   end
endmodule : tb_top
